// file: verilog/sdhs_status_counter.v
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "sdhs_map.vh"

// What this block does
// - Leaving idle for a wait state loads the counter from the length setting
// - Counter counts down during transfer; at zero go idle and flag data end
// - Count register reads 25-bit bytes remaining; writes are ignored
// - Status bits 22 and 10:0 are sticky until cleared by software
// - Status bits 21:11 follow live buffer and transfer state
// - With flow control, transmit empty asserts at two words left
// - With flow control, receive full asserts two words before full
// - Receive half full asserts at eight or more words held
// - Transmit half empty asserts when eight or more words fit
// - Bits 13, 12, 11 show receive, transmit and command in progress
// - Per block, bit 10 on good CRC, bit 1 on bad CRC
// - Wide bus: bit 9 set when start bit missing on any data line
// - Bit 7 command sent, bit 6 response CRC good, bit 0 bad
// - Bit 2 set when no response within 64 card clock periods
// - Bit 5 receive overrun, bit 4 transmit underrun, bit 3 data timeout
// - Bit 8 set when the data counter reaches zero
// - Bit 22 set when the card signals an I/O interrupt
// - Writing 1 to a clear bit clears that flag; 0 leaves it
// - Clear bits exist only for 22 and 10:0; live flags cannot clear
// - Transfer enable starts a transfer into send or receive wait by direction
// - Mask register holds one enable per status bit
module sdhs_status_counter (
   input wire clk_i,
   input wire resetn_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output wire hreadyout_o,
   output wire hresp_o,
   output reg [31:0] hrdata_o,
   input wire card_tick_i,
   input wire data_start_i,
   input wire byte_moved_i,
   input wire block_done_i,
   input wire block_crc_ok_i,
   input wire start_bit_missing_i,
   input wire cmd_active_i,
   input wire cmd_sent_noresp_i,
   input wire resp_wait_i,
   input wire resp_done_i,
   input wire resp_crc_ok_i,
   input wire rx_overrun_i,
   input wire tx_underrun_i,
   input wire data_timeout_i,
   input wire card_irq_i,
   input wire [5:0] rx_level_i,
   input wire [5:0] tx_level_i,
   output wire data_busy_o,
   output wire data_dir_o,
   output wire rx_dma_req_o,
   output wire tx_dma_req_o,
   output wire irq_o
);

   // ----------------------------------------
   // States of the data path state machine
   // ----------------------------------------
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_WAIT_S = 5'h02;
   localparam [4:0] ST_WAIT_R = 5'h04;
   localparam [4:0] ST_SEND = 5'h08;
   localparam [4:0] ST_RECV = 5'h10;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function at_least;
      input [5:0] level;
      input [5:0] limit;
      begin
         at_least = (level >= limit);
      end
   endfunction

   function [31:0] pad_low;
      input [24:0] value;
      begin
         pad_low = {7'h00, value};
      end
   endfunction

   // ----------------------------------------
   // Bus capture
   // ----------------------------------------
   reg wr_pend;
   reg [7:0] wr_addr;
   wire addr_phase;
   wire rd_take;

   // Only a valid transfer with the bus ready opens an address phase
   assign addr_phase = hsel_i && htrans_i[1] && hready_i;
   assign rd_take = addr_phase && !hwrite_i;

   // Zero wait states and never an error
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_phase && hwrite_i;
         wr_addr <= {haddr_i[7:2], 2'b00};
      end
   end

   wire wr_len;
   wire wr_ctrl;
   wire wr_clr;
   wire wr_mask;

   // Upper address bits are not decoded beyond the block window
   assign wr_len = wr_pend && (wr_addr == `SDHS_OFS_LEN);
   assign wr_ctrl = wr_pend && (wr_addr == `SDHS_OFS_CTRL);
   assign wr_clr = wr_pend && (wr_addr == `SDHS_OFS_CLR);
   assign wr_mask = wr_pend && (wr_addr == `SDHS_OFS_MASK);

   // ----------------------------------------
   // Software settings
   // ----------------------------------------
   reg [24:0] length_setting;
   reg [3:0] ctrl;
   reg [22:0] mask_word;

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         length_setting <= `SDHS_LEN_RST;
         ctrl <= 4'h0;
         mask_word <= `SDHS_MASK_RST;
      end else begin
         if (wr_len) begin
            length_setting <= hwdata_i[24:0];
         end
         if (wr_ctrl) begin
            ctrl <= hwdata_i[3:0];
         end
         if (wr_mask) begin
            mask_word <= hwdata_i[22:0];
         end
      end
   end

   wire flow_on;
   wire wide_on;
   wire start_req;

   assign flow_on = ctrl[`SDHS_CTRL_FLOW];
   assign wide_on = ctrl[`SDHS_CTRL_WIDE];
   // A new transfer needs a fresh write of the control word with enable set
   assign start_req = wr_ctrl && hwdata_i[`SDHS_CTRL_EN];

   // ----------------------------------------
   // Data path state machine and counter
   // ----------------------------------------
   reg [4:0] state;
   reg [4:0] next_state;
   reg [24:0] remaining;
   reg [24:0] next_remaining;
   reg data_end;
   reg next_data_end;

   always @* begin
      next_state = state;
      next_remaining = remaining;
      next_data_end = 1'b0;
      case (state)
         ST_IDLE: begin
            if (start_req) begin
               // Direction comes from the same write that enables
               if (hwdata_i[`SDHS_CTRL_DIR]) begin
                  next_state = ST_WAIT_R;
               end else begin
                  next_state = ST_WAIT_S;
               end
               next_remaining = length_setting;
            end
         end
         ST_WAIT_S: begin
            if (remaining == 25'h0000000) begin
               next_state = ST_IDLE;
               next_data_end = 1'b1;
            end else if (data_start_i) begin
               next_state = ST_SEND;
            end
         end
         ST_WAIT_R: begin
            if (remaining == 25'h0000000) begin
               next_state = ST_IDLE;
               next_data_end = 1'b1;
            end else if (data_start_i) begin
               next_state = ST_RECV;
            end
         end
         ST_SEND, ST_RECV: begin
            if (remaining == 25'h0000000) begin
               next_state = ST_IDLE;
               next_data_end = 1'b1;
            end else if (byte_moved_i) begin
               next_remaining = remaining - 25'h0000001;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ST_IDLE;
         remaining <= 25'h0000000;
         data_end <= 1'b0;
      end else begin
         state <= next_state;
         remaining <= next_remaining;
         data_end <= next_data_end;
      end
   end

   assign data_busy_o = (state != ST_IDLE);
   assign data_dir_o = (state == ST_WAIT_R) || (state == ST_RECV);

   // ----------------------------------------
   // Command response timeout
   // ----------------------------------------
   wire resp_expired;

   sdhs_resp_timer u_resp_timer (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wait_i(resp_wait_i),
      .card_tick_i(card_tick_i),
      .expired_o(resp_expired)
   );

   // ----------------------------------------
   // Live indications
   // ----------------------------------------
   wire rx_avail;
   wire tx_avail;
   wire rx_empty;
   wire tx_empty;
   wire rx_full;
   wire tx_full;
   wire rx_half;
   wire tx_half;
   wire [5:0] tx_room;

   assign rx_avail = (rx_level_i != 6'h00);
   assign tx_avail = (tx_level_i != 6'h00);
   assign rx_empty = (rx_level_i == 6'h00);
   // Early warnings leave slack for the card clock to be held off
   assign tx_empty = flow_on ? !at_least(tx_level_i, `SDHS_FLOW_MARGIN + 6'h01)
      : (tx_level_i == 6'h00);
   assign rx_full = flow_on
      ? at_least(rx_level_i, `SDHS_FIFO_DEPTH - `SDHS_FLOW_MARGIN)
      : at_least(rx_level_i, `SDHS_FIFO_DEPTH);
   assign tx_full = at_least(tx_level_i, `SDHS_FIFO_DEPTH);
   assign rx_half = at_least(rx_level_i, `SDHS_HALF_WORDS);
   assign tx_room = `SDHS_FIFO_DEPTH - tx_level_i;
   assign tx_half = at_least(tx_room, `SDHS_HALF_WORDS);

   assign rx_dma_req_o = rx_half;
   assign tx_dma_req_o = tx_half;

   wire [22:0] live;

   assign live = {1'b0, rx_avail, tx_avail, rx_empty, tx_empty, rx_full, tx_full,
      rx_half, tx_half, (state == ST_RECV), (state == ST_SEND), cmd_active_i,
      11'h000};

   // ----------------------------------------
   // Sticky flags
   // ----------------------------------------
   reg [22:0] sticky;
   wire [22:0] set_vec;
   wire [22:0] clr_vec;

   assign set_vec[`SDHS_ST_CARDIRQ] = card_irq_i;
   assign set_vec[21:11] = 11'h000;
   assign set_vec[`SDHS_ST_BLKOK] = block_done_i && block_crc_ok_i;
   assign set_vec[`SDHS_ST_SBERR] = start_bit_missing_i && wide_on;
   assign set_vec[`SDHS_ST_DEND] = data_end;
   assign set_vec[`SDHS_ST_CSENT] = cmd_sent_noresp_i;
   assign set_vec[`SDHS_ST_RSPOK] = resp_done_i && resp_crc_ok_i;
   assign set_vec[`SDHS_ST_RXOVR] = rx_overrun_i;
   assign set_vec[`SDHS_ST_TXUND] = tx_underrun_i;
   assign set_vec[`SDHS_ST_DTOUT] = data_timeout_i;
   assign set_vec[`SDHS_ST_RTOUT] = resp_expired;
   assign set_vec[`SDHS_ST_BLKERR] = block_done_i && !block_crc_ok_i;
   assign set_vec[`SDHS_ST_RSPERR] = resp_done_i && !resp_crc_ok_i;

   // Reserved clear bits are masked off so live flags stay untouched
   assign clr_vec = wr_clr ? (hwdata_i[22:0] & `SDHS_CLR_MASK) : 23'h000000;

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sticky <= 23'h000000;
      end else begin
         // A set in the clearing cycle wins so no event is lost
         sticky <= ((sticky & ~clr_vec) | set_vec) & `SDHS_STICKY_MASK;
      end
   end

   wire [22:0] status_word;

   assign status_word = sticky | live;

   // ----------------------------------------
   // Interrupt request
   // ----------------------------------------
   assign irq_o = |(status_word & mask_word);

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   reg [31:0] next_rdata;

   always @* begin
      next_rdata = 32'h00000000;
      case ({haddr_i[7:2], 2'b00})
         `SDHS_OFS_LEN: begin
            next_rdata = pad_low(length_setting);
         end
         `SDHS_OFS_CTRL: begin
            next_rdata = {28'h0000000, ctrl};
         end
         `SDHS_OFS_COUNT: begin
            // Reads the live down counter, also while a transfer runs
            next_rdata = pad_low(remaining);
         end
         `SDHS_OFS_STAT: begin
            next_rdata = {9'h000, status_word};
         end
         `SDHS_OFS_MASK: begin
            next_rdata = {9'h000, mask_word};
         end
         default: begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hrdata_o <= 32'h00000000;
      end else if (rd_take) begin
         hrdata_o <= next_rdata;
      end
   end

endmodule

// file: verilog/sdhs_map.vh
`ifndef SDHS_MAP_VH
`define SDHS_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SDHS_OFS_LEN 8'h00
`define SDHS_OFS_CTRL 8'h04
`define SDHS_OFS_COUNT 8'h08
`define SDHS_OFS_STAT 8'h0c
`define SDHS_OFS_CLR 8'h10
`define SDHS_OFS_MASK 8'h14

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define SDHS_CTRL_EN 0
`define SDHS_CTRL_DIR 1
`define SDHS_CTRL_FLOW 2
`define SDHS_CTRL_WIDE 3
`define SDHS_CTRL_W 4

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define SDHS_ST_CARDIRQ 22
`define SDHS_ST_RXAV 21
`define SDHS_ST_TXAV 20
`define SDHS_ST_RXE 19
`define SDHS_ST_TXE 18
`define SDHS_ST_RXF 17
`define SDHS_ST_TXF 16
`define SDHS_ST_RXH 15
`define SDHS_ST_TXH 14
`define SDHS_ST_RXACT 13
`define SDHS_ST_TXACT 12
`define SDHS_ST_CMDACT 11
`define SDHS_ST_BLKOK 10
`define SDHS_ST_SBERR 9
`define SDHS_ST_DEND 8
`define SDHS_ST_CSENT 7
`define SDHS_ST_RSPOK 6
`define SDHS_ST_RXOVR 5
`define SDHS_ST_TXUND 4
`define SDHS_ST_DTOUT 3
`define SDHS_ST_RTOUT 2
`define SDHS_ST_BLKERR 1
`define SDHS_ST_RSPERR 0
`define SDHS_STAT_W 23
`define SDHS_STICKY_MASK 23'h4007ff
`define SDHS_CLR_MASK 23'h4007ff

// ----------------------------------------
// Widths, reset values and timing
// ----------------------------------------
`define SDHS_COUNT_W 25
`define SDHS_LEN_RST 25'h0000000
`define SDHS_MASK_RST 23'h000000
`define SDHS_LVL_W 6
`define SDHS_FIFO_DEPTH 6'h20
`define SDHS_HALF_WORDS 6'h08
`define SDHS_FLOW_MARGIN 6'h02
`define SDHS_RESP_TIMEOUT_CK 7'h40

`endif

// file: verilog/sdhs_resp_timer.v
`timescale 1ns/1ps
`include "sdhs_map.vh"

// Counts card clock periods while a response is awaited; fires once
module sdhs_resp_timer (
   input wire clk_i,
   input wire resetn_i,
   input wire wait_i,
   input wire card_tick_i,
   output reg expired_o
);

   reg [6:0] periods;
   reg fired;

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         periods <= 7'h00;
         fired <= 1'b0;
         expired_o <= 1'b0;
      end else begin
         expired_o <= 1'b0;
         if (!wait_i) begin
            periods <= 7'h00;
            fired <= 1'b0;
         end else if (card_tick_i && !fired) begin
            // Fixed window, not programmable
            if (periods == `SDHS_RESP_TIMEOUT_CK - 7'h01) begin
               expired_o <= 1'b1;
               fired <= 1'b1;
            end else begin
               periods <= periods + 7'h01;
            end
         end
      end
   end

endmodule

// file: sim/sdhs_status_counter_assertions.sv
`timescale 1ns/1ps
`include "sdhs_map.vh"
module sdhs_status_counter_assertions (
   input wire clk_i,
   input wire resetn_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   input wire hreadyout_o,
   input wire hresp_o,
   input wire [31:0] hrdata_o,
   input wire cmd_active_i,
   input wire [5:0] rx_level_i,
   input wire [5:0] tx_level_i,
   input wire data_busy_o,
   input wire data_dir_o,
   input wire rx_dma_req_o,
   input wire tx_dma_req_o
);
   // ----------
   // Bus phase tracking
   // ----------
   reg rd_st;
   reg rd_count;
   reg wr_ctl;
   wire take = hsel_i & htrans_i[1] & hready_i;
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {rd_st, rd_count, wr_ctl} <= 3'h0;
      end else begin
         rd_st <= take & ~hwrite_i & (haddr_i[7:0] == `SDHS_OFS_STAT);
         rd_count <= take & ~hwrite_i & (haddr_i[7:0] == `SDHS_OFS_COUNT);
         wr_ctl <= take & hwrite_i & (haddr_i[7:0] == `SDHS_OFS_CTRL);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus slave not ready or not okay");
   a_rx_dma: assert property (rx_dma_req_o == (rx_level_i >= `SDHS_HALF_WORDS))
      else $error("receive dma request wrong");
   a_tx_dma: assert property (tx_dma_req_o == ((`SDHS_FIFO_DEPTH - tx_level_i) >= 6'h08))
      else $error("transmit dma request wrong");
   a_start_busy: assert property (wr_ctl && hwdata_i[`SDHS_CTRL_EN] && !data_busy_o
      |=> data_busy_o && data_dir_o == $past(hwdata_i[`SDHS_CTRL_DIR]))
      else $error("transfer did not start as programmed");
   a_busy_cause: assert property ($rose(data_busy_o) |-> $past(wr_ctl && hwdata_i[0]))
      else $error("transfer started without enable");
   a_dir_hold: assert property (data_busy_o && $past(data_busy_o) |-> $stable(data_dir_o))
      else $error("direction changed mid transfer");
   a_count_upper: assert property (rd_count |-> hrdata_o[31:25] == 7'h00)
      else $error("count upper bits not zero");
   a_stat_upper: assert property (rd_st |-> hrdata_o[31:23] == 9'h000)
      else $error("status upper bits not zero");
   a_cmd_live: assert property (rd_st |-> hrdata_o[`SDHS_ST_CMDACT] == $past(cmd_active_i))
      else $error("command active bit not live");
   a_half_live: assert property (rd_st |-> hrdata_o[15] == ($past(rx_level_i) >= 6'h08))
      else $error("receive half bit not live");
endmodule
bind sdhs_status_counter sdhs_status_counter_assertions sdhs_status_counter_assertions_inst (.*);

// file: sim/sdhs_card_model.sv
`timescale 1ns/1ps
module sdhs_card_model (
   input wire clk_i,
   input wire resetn_i,
   input wire data_busy_i,
   input wire [1:0] gap_i,
   input wire [24:0] len_i,
   output reg card_tick_o,
   output reg data_start_o,
   output reg byte_moved_o,
   output reg [24:0] sent_o
);
   // Card clock runs free at a quarter rate, as it also paces response timeouts
   reg [1:0] div;
   reg [1:0] wt;
   reg started;
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {div, wt, card_tick_o, data_start_o, byte_moved_o, started} <= 8'h00;
         sent_o <= 25'h0;
      end else begin
         div <= div + 2'h1;
         card_tick_o <= (div == 2'h3);
         data_start_o <= 1'b0;
         byte_moved_o <= 1'b0;
         if (!data_busy_i) begin
            started <= 1'b0;
            wt <= gap_i;
         end else if (wt != 2'h0) begin
            wt <= wt - 2'h1;
         end else if (!started) begin
            data_start_o <= 1'b1;
            started <= 1'b1;
            sent_o <= 25'h0;
            wt <= gap_i;
         end else if (sent_o != len_i) begin
            // Stops at the programmed length like the real engine, never beyond
            byte_moved_o <= 1'b1;
            sent_o <= sent_o + 25'h1;
            wt <= gap_i;
         end
      end
   end
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
`include "sdhs_map.vh"
module tb_top;
   reg clk_i, resetn_i, hsel_i, hwrite_i, block_done_i, block_crc_ok_i;
   reg start_bit_missing_i, cmd_active_i, cmd_sent_noresp_i, resp_wait_i, resp_done_i;
   reg resp_crc_ok_i, rx_overrun_i, tx_underrun_i, data_timeout_i, card_irq_i;
   reg [31:0] haddr_i, hwdata_i, rd;
   reg [1:0] htrans_i, gap;
   reg [2:0] hsize_i;
   reg [5:0] rx_level_i, tx_level_i;
   reg [24:0] len;
   wire hreadyout_o, hresp_o, data_busy_o, data_dir_o, rx_dma_req_o, tx_dma_req_o, irq_o;
   wire card_tick_i, data_start_i, byte_moved_i;
   wire [31:0] hrdata_o;
   wire [24:0] sent;
   wire hready_i = hreadyout_o;
   integer fail_count, num_checks, seed, i, k, n;
   sdhs_status_counter sdhs_status_counter_inst (.*);
   sdhs_card_model sdhs_card_model_inst (.clk_i(clk_i), .resetn_i(resetn_i),
      .data_busy_i(data_busy_o), .gap_i(gap), .len_i(len), .card_tick_o(card_tick_i),
      .data_start_o(data_start_i), .byte_moved_o(byte_moved_i), .sent_o(sent));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ----------
   // Helpers
   // ----------
   task conclude;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task bound(input integer b);
      if (b > 500) begin
         chk(32'h0, 32'h1);
         conclude;
      end
   endtask
   task wait_rdy;
      integer w;
      // Own counter so that a bus wait never disturbs the tick count in n
      for (w = 0; hreadyout_o !== 1'b1; w = w + 1) begin
         bound(w);
         @(posedge clk_i);
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         hsel_i <= 1'b1;
         haddr_i <= {24'h000000, a};
         hwrite_i <= w;
         htrans_i <= 2'b10;
         @(posedge clk_i);
         wait_rdy;
         hsel_i <= 1'b0;
         htrans_i <= 2'b00;
         hwdata_i <= d;
         @(posedge clk_i);
         wait_rdy;
         rd = hrdata_o;
      end
   endtask
   task ev(input integer e);
      begin
         case (e)
            0: {block_done_i, block_crc_ok_i} <= 2'h3;
            1: {block_done_i, block_crc_ok_i} <= 2'h2;
            2: start_bit_missing_i <= 1'b1;
            3: cmd_sent_noresp_i <= 1'b1;
            4: {resp_done_i, resp_crc_ok_i} <= 2'h3;
            5: {resp_done_i, resp_crc_ok_i} <= 2'h2;
            6: rx_overrun_i <= 1'b1;
            7: tx_underrun_i <= 1'b1;
            8: data_timeout_i <= 1'b1;
            default: card_irq_i <= 1'b1;
         endcase
         @(posedge clk_i);
         {block_done_i, start_bit_missing_i, cmd_sent_noresp_i, resp_done_i} <= 4'h0;
         {rx_overrun_i, tx_underrun_i, data_timeout_i, card_irq_i} <= 4'h0;
         @(posedge clk_i);
      end
   endtask
   task tk(input integer m);
      integer b;
      for (b = 0; n < m; b = b + 1) begin
         bound(b);
         @(negedge clk_i);
         if (card_tick_i === 1'b1) n = n + 1;
      end
   endtask
   function [22:0] ebit(input integer e);
      ebit = 23'h000001 << ((e == 9) ? 22 : (e == 0) ? 10 : (e == 1) ? 1 : (e == 2) ? 9 :
         (e == 5) ? 0 : (e > 5) ? 11 - e : 10 - e);
   endfunction
   function [10:0] live(input [5:0] r, input [5:0] t, input f, input c);
      live = {r != 6'h00, t != 6'h00, r == 6'h00, f ? t <= 6'h02 : t == 6'h00,
         f ? r >= 6'h1e : r == 6'h20, t == 6'h20, r >= 6'h08, t <= 6'h18, 2'b00, c};
   endfunction
   // ----------
   // Main sequence
   // ----------
   initial begin
      fail_count = 0;
      num_checks = 0;
      seed = 32'h99b4;
      {resetn_i, hsel_i, hwrite_i, block_done_i, block_crc_ok_i, start_bit_missing_i} = 6'h00;
      {cmd_active_i, cmd_sent_noresp_i, resp_wait_i, resp_done_i, resp_crc_ok_i} = 5'h00;
      {rx_overrun_i, tx_underrun_i, data_timeout_i, card_irq_i, htrans_i, gap} = 8'h00;
      {haddr_i, hwdata_i, rx_level_i, tx_level_i, len} = 101'h0;
      hsize_i = 3'h2;
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      bus(1'b0, `SDHS_OFS_MASK, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, `SDHS_OFS_STAT, 32'h0);
      chk(rd, {9'h000, live(6'h00, 6'h00, 1'b0, 1'b0), 11'h000});
      for (i = 0; i < 16; i = i + 1) begin
         rx_level_i <= (i < 6) ? 6'h1b + i : (i < 8) ? 6'h01 + i : {$random(seed)} % 33;
         tx_level_i <= (i < 6) ? 6'h05 - i : (i < 8) ? 6'h12 + i : {$random(seed)} % 33;
         cmd_active_i <= i[1];
         bus(1'b1, `SDHS_OFS_CTRL, {29'h0, i[0], 2'b00});
         bus(1'b1, `SDHS_OFS_CLR, 32'hffffffff);
         bus(1'b0, `SDHS_OFS_STAT, 32'h0);
         chk(rd[21:11], live(rx_level_i, tx_level_i, i[0], i[1]));
         chk(rx_dma_req_o, rx_level_i >= 6'h08);
      end
      bus(1'b1, `SDHS_OFS_MASK, 32'hffffffff);
      bus(1'b0, `SDHS_OFS_MASK, 32'h0);
      chk(rd, 32'h007fffff);
      bus(1'b1, `SDHS_OFS_MASK, {9'h000, `SDHS_STICKY_MASK});
      bus(1'b1, `SDHS_OFS_CTRL, 32'h8);
      for (k = 0; k < 10; k = k + 1) begin
         ev(k);
         chk(irq_o, 1'b1);
         bus(1'b1, `SDHS_OFS_CLR, {9'h000, ~ebit(k)});
         bus(1'b0, `SDHS_OFS_STAT, 32'h0);
         chk(rd[22:0] & `SDHS_STICKY_MASK, ebit(k));
         bus(1'b1, `SDHS_OFS_CLR, {9'h000, ebit(k)});
         bus(1'b0, `SDHS_OFS_STAT, 32'h0);
         chk(rd[22:0] & `SDHS_STICKY_MASK, 32'h0);
         chk(irq_o, 1'b0);
      end
      bus(1'b1, `SDHS_OFS_CTRL, 32'h0);
      ev(2);
      bus(1'b0, `SDHS_OFS_STAT, 32'h0);
      chk(rd[`SDHS_ST_SBERR], 1'b0);
      resp_wait_i <= 1'b1;
      n = 0;
      tk(63);
      repeat (2) @(posedge clk_i);
      bus(1'b0, `SDHS_OFS_STAT, 32'h0);
      chk(rd[`SDHS_ST_RTOUT], 1'b0);
      tk(64);
      repeat (2) @(posedge clk_i);
      bus(1'b0, `SDHS_OFS_STAT, 32'h0);
      chk(rd[`SDHS_ST_RTOUT], 1'b1);
      resp_wait_i <= 1'b0;
      bus(1'b1, `SDHS_OFS_CLR, 32'h4);
      for (k = 0; k < 6; k = k + 1) begin
         len <= (k == 0) ? 25'h0 : {$random(seed)} % 40 + 1;
         gap <= k[1:0];
         @(posedge clk_i);
         bus(1'b1, `SDHS_OFS_LEN, {7'h00, len});
         bus(1'b1, `SDHS_OFS_CTRL, {30'h0, k[0], 1'b1});
         if (k != 0) begin
            for (i = 0; data_start_i !== 1'b1; i = i + 1) begin
               bound(i);
               @(posedge clk_i);
            end
            bus(1'b0, `SDHS_OFS_STAT, 32'h0);
            chk(rd[13:12], {k[0], ~k[0]});
         end
         @(posedge clk_i);
         for (i = 0; data_busy_o !== 1'b0; i = i + 1) begin
            bound(i);
            @(posedge clk_i);
         end
         chk(sent, len);
         bus(1'b1, `SDHS_OFS_COUNT, 32'hffffffff);
         bus(1'b0, `SDHS_OFS_COUNT, 32'h0);
         chk(rd, 32'h0);
         bus(1'b0, `SDHS_OFS_STAT, 32'h0);
         chk(rd[`SDHS_ST_DEND], 1'b1);
         bus(1'b1, `SDHS_OFS_CLR, 32'h100);
      end
      conclude;
   end
endmodule
